//--- hdl/dpras_pkg.sv
package dpras_pkg;

	// port pins driven towards one side of the shared memory
	typedef struct packed {
		logic        port_select_n;
		logic        write_not_read;
		logic        output_enable_n;
		logic        upper_lane_select_n;
		logic        lower_lane_select_n;
		logic        flag_space_select_n;
		logic [15:0] addr;
	} dpras_pins_s;

	localparam dpras_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};

	// register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// control field positions
	localparam int CTRL_START  = 0;
	localparam int CTRL_WRITE  = 1;
	localparam int CTRL_FLAG   = 2;
	localparam int CTRL_UPPER  = 3;
	localparam int CTRL_LOWER  = 4;
	localparam int CTRL_MASTER = 5;

	// status field positions
	localparam int STAT_ACTIVE  = 0;
	localparam int STAT_MAILBOX = 1;
	localparam int STAT_BUSY    = 2;
	localparam int STAT_TOKEN   = 3;
	localparam int STAT_STALLED = 4;

	// reset values
	localparam logic [5:0]  CTRL_RESET  = 6'h18;
	localparam logic [15:0] ADDR_RESET  = 16'h0000;
	localparam logic [15:0] WDATA_RESET = 16'h0000;

	// mailbox words
	localparam logic [15:0] MBOX_RIGHT_WORD = 16'h7fff;
	localparam logic [15:0] MBOX_LEFT_WORD  = 16'h7ffe;

	// timing
	localparam int CLK_PERIOD_NS          = 100;
	localparam int FLAG_CONTENTION_NS     = 5;
	localparam int PRIORITY_SETUP_NS      = 5;
	localparam int SETUP_NS               = (FLAG_CONTENTION_NS > PRIORITY_SETUP_NS) ?
		FLAG_CONTENTION_NS : PRIORITY_SETUP_NS;
	localparam int SETUP_CYC_RAW          = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SETUP_CYC      = 4'((SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW);
	localparam int SYNC_STAGES            = 2;
	localparam logic [3:0] READ_WAIT_CYC  = 4'(SYNC_STAGES + 1);

	// engine states
	typedef enum logic [6:0] {
		S_IDLE  = 7'b0000001,
		S_SETUP = 7'b0000010,
		S_WRITE = 7'b0000100,
		S_WREC  = 7'b0001000,
		S_READ  = 7'b0010000,
		S_RCAP  = 7'b0100000,
		S_DONE  = 7'b1000000
	} dpras_state_e;

endpackage

//--- hdl/dpras_sync.sv
`timescale 1ns/1ns
`default_nettype none

module dpras_sync
	import dpras_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             ce_i,
	// level in and out
	input  wire logic [WIDTH-1:0] d_i,
	input  wire logic [WIDTH-1:0] rst_val_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;

	// rst_val_i is a constant at every instance
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			stage1 <= rst_val_i;
			stage2 <= rst_val_i;
		end else if (ce_i) begin
			stage1 <= d_i;
			stage2 <= stage1;
		end
	end

	assign q_o = stage2;

endmodule

`default_nettype wire

//--- hdl/dpras_host.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// - Keep write_not_read high whenever the port address changes.
// - Never drive data while the device may still drive it.
// - Keep port select high across flag write and read-back.
// - In slave role a low busy input stalls the port write.
module dpras_host
	import dpras_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// memory port pins
	output dpras_pins_s      pins_o,
	input  wire logic [15:0] data_i,
	output logic      [15:0] data_o,
	output logic             data_oe_o,
	input  wire logic        mailbox_flag_n_i,
	input  wire logic        busy_n_i,
	output logic             arbiter_role_select_o
);

	dpras_state_e state;
	dpras_state_e next_state;
	dpras_pins_s  next_pins;

	logic [5:0]  ctrl;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        token;
	logic        stalled;
	logic [3:0]  cnt;
	logic        next_data_oe;

	logic [15:0] data_s;
	logic        mbox_n_s;
	logic        busy_n_s;

	logic        req;
	logic        req_wr;
	logic        start;
	logic        active;
	logic        is_flag;
	logic        busy_hold;

	// pin inputs through two flops
	dpras_sync #(.WIDTH(18)) u_sync (
		.clk_i     (clk_i),
		.rstn_i    (rstn_i),
		.ce_i      (ce_i),
		.d_i       ({data_i, mailbox_flag_n_i, busy_n_i}),
		.rst_val_i ({16'h0000, 1'b1, 1'b1}),
		.q_o       ({data_s, mbox_n_s, busy_n_s})
	);

	assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign req_wr  = req && wb_we_i;
	assign start   = req_wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_START];
	assign active  = (state != S_IDLE);
	assign is_flag = ctrl[CTRL_FLAG];
	// flag accesses bypass the arbiter, memory accesses honour busy
	assign busy_hold = !is_flag && !busy_n_s;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i && req) begin
			case (wb_adr_i)
				REG_CTRL:   wb_dat_o <= {26'h0, ctrl};
				REG_ADDR:   wb_dat_o <= {16'h0, addr};
				REG_WDATA:  wb_dat_o <= {16'h0, wdata};
				REG_RDATA:  wb_dat_o <= {16'h0, rdata};
				REG_STATUS: wb_dat_o <= {27'h0, stalled, token, !busy_n_s, !mbox_n_s, active};
				default:    wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// settings are frozen while an access runs
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ctrl  <= CTRL_RESET;
			addr  <= ADDR_RESET;
			wdata <= WDATA_RESET;
		end else if (ce_i && req_wr && !active) begin
			case (wb_adr_i)
				REG_CTRL: begin
					if (wb_sel_i[0]) begin
						ctrl <= {wb_dat_i[5:1], 1'b0};
					end
				end
				REG_ADDR: begin
					if (wb_sel_i[0]) begin
						addr[7:0] <= wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						addr[15:8] <= wb_dat_i[15:8];
					end
				end
				REG_WDATA: begin
					if (wb_sel_i[0]) begin
						wdata[7:0] <= wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						wdata[15:8] <= wb_dat_i[15:8];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// role strap follows the control bit
	// master role select
	assign arbiter_role_select_o = ctrl[CTRL_MASTER];

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (start) begin
					next_state = S_SETUP;
				end
			end
			S_SETUP: begin
				if (cnt == 4'h0) begin
					next_state = ctrl[CTRL_WRITE] ? S_WRITE : S_READ;
				end
			end
			S_WRITE: begin
				if (!busy_hold) begin
					next_state = S_WREC;
				end
			end
			S_WREC:  next_state = S_DONE;
			S_READ: begin
				if (cnt == 4'h0 && !busy_hold) begin
					next_state = S_RCAP;
				end
			end
			S_RCAP:  next_state = S_DONE;
			S_DONE:  next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state <= S_IDLE;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	// setup wait covers flag contention and priority setup windows
	// contention spacing
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cnt <= 4'h0;
		end else if (ce_i) begin
			if (next_state == S_SETUP && state != S_SETUP) begin
				cnt <= SETUP_CYC - 4'h1;
			end else if (next_state == S_READ && state != S_READ) begin
				cnt <= READ_WAIT_CYC;
			end else if (state == S_READ && busy_hold) begin
				cnt <= READ_WAIT_CYC;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
		end
	end

	always_comb begin
		next_pins      = PINS_IDLE;
		next_pins.addr = pins_o.addr;
		next_data_oe   = 1'b0;
		case (next_state)
			S_SETUP: begin
				next_pins.addr = addr;
			end
			S_WRITE: begin
				next_pins.write_not_read = 1'b0;
				next_data_oe             = 1'b1;
				if (is_flag) begin
					next_pins.flag_space_select_n = 1'b0;
				end else begin
					next_pins.port_select_n       = 1'b0;
					next_pins.upper_lane_select_n = !ctrl[CTRL_UPPER];
					next_pins.lower_lane_select_n = !ctrl[CTRL_LOWER];
				end
			end
			// output enable stays high so data lines are ours
			S_WREC: begin
				next_data_oe = 1'b1;
			end
			S_READ, S_RCAP: begin
				next_pins.output_enable_n = 1'b0;
				if (is_flag) begin
					next_pins.flag_space_select_n = 1'b0;
				end else begin
					next_pins.port_select_n       = 1'b0;
					next_pins.upper_lane_select_n = !ctrl[CTRL_UPPER];
					next_pins.lower_lane_select_n = !ctrl[CTRL_LOWER];
				end
			end
			default: begin
			end
		endcase
	end

	// write_not_read is high in setup, so select never trails its fall
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pins_o    <= PINS_IDLE;
			data_oe_o <= 1'b0;
		end else if (ce_i) begin
			pins_o    <= next_pins;
			data_oe_o <= next_data_oe;
		end
	end

	// flag value sits in bit 0 only
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			data_o <= 16'h0000;
		end else if (ce_i && next_state == S_WRITE) begin
			data_o <= is_flag ? {15'h0000, wdata[0]} : wdata;
		end
	end

	// in memory reads an unselected lane reads back as zero; flag reads keep all 16 bits
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rdata <= 16'h0000;
		end else if (ce_i && state == S_RCAP) begin
			if (is_flag) begin
				rdata <= data_s;
			end else begin
				rdata <= {ctrl[CTRL_UPPER] ? data_s[15:8] : 8'h00,
					ctrl[CTRL_LOWER] ? data_s[7:0] : 8'h00};
			end
		end
	end

	// token seen by the last flag read-back
	// owner reads zero
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			token <= 1'b0;
		end else if (ce_i && state == S_RCAP && is_flag) begin
			token <= !data_s[0];
		end
	end

	// sticky stall indicator, cleared by the next start
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			stalled <= 1'b0;
		end else if (ce_i) begin
			if ((state == S_WRITE || state == S_READ) && busy_hold) begin
				stalled <= 1'b1;
			end else if (start) begin
				stalled <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

//--- verification/dpras_host_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module dpras_host_asserts
	import dpras_pkg::*;
(
	// watched ports
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic        wb_ack_o,
	input wire dpras_pins_s pins_o,
	input wire logic        data_oe_o,
	input wire logic        busy_n_i,
	input wire logic        arbiter_role_select_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	ack_in_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	addr_move_a: assert property ($changed(pins_o.addr) |->
		pins_o.write_not_read && $past(pins_o.write_not_read)) else $error("addr moved");
	write_data_a: assert property (!pins_o.write_not_read |-> data_oe_o)
		else $error("write without data");
	select_order_a: assert property ($fell(pins_o.write_not_read) |->
		$past(pins_o.port_select_n && pins_o.flag_space_select_n)) else $error("select early");
	no_contend_a: assert property (data_oe_o |-> pins_o.output_enable_n)
		else $error("bus contention");
	flag_deselect_a: assert property (!pins_o.flag_space_select_n |-> pins_o.port_select_n)
		else $error("select in flag access");
	stall_hold_a: assert property ((!pins_o.write_not_read && !pins_o.port_select_n
		&& !busy_n_i) [*3] |=> !pins_o.write_not_read) else $error("write not stalled");
	role_write_a: assert property ($changed(arbiter_role_select_o) |->
		$past(wb_cyc_i && wb_we_i && wb_adr_i == REG_CTRL)) else $error("role moved");
endmodule
bind dpras_host dpras_host_asserts i_chk (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
	.pins_o(pins_o), .data_oe_o(data_oe_o), .busy_n_i(busy_n_i),
	.arbiter_role_select_o(arbiter_role_select_o));
`default_nettype wire

//--- verification/dpras_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module dpras_mem_model
	import dpras_pkg::*;
(
	// host side pins
	input  wire logic        clk_i,
	input  wire dpras_pins_s pins_i,
	input  wire logic [15:0] bus_i,
	input  wire logic        role_i,
	// far side events
	input  wire logic        far_mbox_i,
	input  wire logic        far_sem_i,
	input  wire logic        far_bit_i,
	input  wire logic        far_hold_i,
	input  wire logic        ext_busy_n_i,
	// towards host
	output logic      [15:0] data_o,
	output logic             mbox_n_o,
	output logic             far_mbox_n_o,
	output logic             busy_n_o
);
	logic [15:0] mem [16];
	logic [15:0] drift;
	logic        own;
	logic        far_own;
	logic        near_pend;
	logic        far_pend;
	wire logic [3:0] a = pins_i.addr[3:0];
	wire logic ul = !pins_i.upper_lane_select_n;
	wire logic ll = !pins_i.lower_lane_select_n;
	wire logic ram = !pins_i.port_select_n && pins_i.flag_space_select_n;
	wire logic flag_space_select = !pins_i.flag_space_select_n && (pins_i.port_select_n || !(ul || ll));
	// lanes are driven only while write_not_read is high
	wire logic rd = pins_i.write_not_read && !pins_i.output_enable_n;
	wire logic wr = !pins_i.write_not_read;
	wire logic near_req = wr && flag_space_select && !bus_i[0];
	wire logic near_rel = wr && flag_space_select && bus_i[0];
	wire logic far_req = far_sem_i && !far_bit_i;
	wire logic far_rel = far_sem_i && far_bit_i;
	// far port came first on this word, so this side waits
	assign busy_n_o = role_i ? !(far_hold_i && ram) : ext_busy_n_i;
	initial begin
		drift = 16'h3c3c;
		own = 1'b0;
		far_own = 1'b0;
		near_pend = 1'b0;
		far_pend = 1'b0;
		for (int i = 0; i < 16; i++)
			mem[i] = 16'h0000;
		mbox_n_o = 1'b1;
		far_mbox_n_o = 1'b1;
	end
	always_comb begin
		data_o = drift;
		if (rd && flag_space_select)
			data_o = {16{!own}};
		if (rd && ram && ul)
			data_o[15:8] = mem[a][15:8];
		if (rd && ram && ll)
			data_o[7:0] = mem[a][7:0];
	end
	always @(posedge clk_i) begin
		drift <= ~drift;
		if (wr && ram && ul)
			mem[a][15:8] <= bus_i[15:8];
		if (wr && ram && ll)
			mem[a][7:0] <= bus_i[7:0];
		// bit zero decides, both ports alike
		if (!own && !far_own) begin
			// a tie goes to this side, the loser waits
			own <= near_req;
			far_own <= far_req && !near_req;
			far_pend <= far_req && near_req;
		end else if (own) begin
			if (far_req)
				far_pend <= 1'b1;
			if (far_rel)
				far_pend <= 1'b0;
			if (near_rel) begin
				own <= 1'b0;
				far_own <= far_pend;
				far_pend <= 1'b0;
			end
		end else begin
			if (near_req)
				near_pend <= 1'b1;
			if (near_rel)
				near_pend <= 1'b0;
			if (far_rel) begin
				far_own <= 1'b0;
				own <= near_pend;
				near_pend <= 1'b0;
			end
		end
		if (wr && ram && pins_i.addr == MBOX_RIGHT_WORD)
			far_mbox_n_o <= 1'b0;
		// set by far, cleared by read
		if (far_mbox_i)
			mbox_n_o <= 1'b0;
		else if (rd && ram && pins_i.addr == MBOX_LEFT_WORD)
			mbox_n_o <= 1'b1;
	end
endmodule
`default_nettype wire

//--- verification/dpras_host_test.sv
`timescale 1ns/1ns
`default_nettype none
module dpras_host_test
	import dpras_pkg::*;
;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic        ebusy_n = 1'b1;
	logic        far = 1'b0;
	logic        far_sem = 1'b0;
	logic        far_bit = 1'b0;
	logic        far_hold = 1'b0;
	logic [31:0] rdat, rq;
	logic [15:0] dout, mdat, din;
	logic        ack, oe, mbox_n, fmb, busy_n, role;
	dpras_pins_s pins;
	int          fails = 0;
	int          checks_done = 0;
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	assign din = oe ? dout : mdat;
	dpras_host i_dut (.clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .pins_o(pins), .data_i(din), .data_o(dout), .data_oe_o(oe),
		.mailbox_flag_n_i(mbox_n), .busy_n_i(busy_n), .arbiter_role_select_o(role));
	dpras_mem_model i_mem (.clk_i(clk), .pins_i(pins), .bus_i(din), .role_i(role),
		.far_mbox_i(far), .far_sem_i(far_sem), .far_bit_i(far_bit), .far_hold_i(far_hold),
		.ext_busy_n_i(ebusy_n), .data_o(mdat), .mbox_n_o(mbox_n),
		.far_mbox_n_o(fmb), .busy_n_o(busy_n));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// bus cycle held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rq = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic go(input logic [5:0] c, input logic [15:0] a, input logic [15:0] d);
		wb(1'b1, REG_ADDR, {16'h0, a});
		wb(1'b1, REG_WDATA, {16'h0, d});
		wb(1'b1, REG_CTRL, {26'h0, c[5:1], 1'b1});
	endtask
	task automatic idle();
		do wb(1'b0, REG_STATUS, 32'h0); while (rq[STAT_ACTIVE] !== 1'b0);
	endtask
	task automatic rdc(input logic [5:0] c, input logic [15:0] a, input logic [15:0] e);
		go(c, a, 16'h0);
		idle();
		wb(1'b0, REG_RDATA, 32'h0);
		chk(rq, {16'h0, e});
	endtask
	// one-cycle flag write by the far port
	task automatic far_flag(input logic b);
		far_bit <= b;
		far_sem <= 1'b1;
		@(posedge clk);
		far_sem <= 1'b0;
	endtask
	initial begin
		#(20000 * CLK_PERIOD_NS);
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		wb(1'b0, REG_CTRL, 32'h0);
		chk(rq, {26'h0, CTRL_RESET});
		wb(1'b1, 8'h14, 32'hffff);
		wb(1'b0, 8'h14, 32'h0);
		chk(rq, 32'h0);
		chk(pins, PINS_IDLE);
		$display("test reset done");
		go(6'h1a, 16'h0003, 16'ha5c3);
		idle();
		go(6'h0a, 16'h0003, 16'h11ff);
		idle();
		rdc(6'h18, 16'h0003, 16'h11c3);
		rdc(6'h08, 16'h0003, 16'h1100);
		rdc(6'h10, 16'h0003, 16'h00c3);
		$display("test lanes done");
		go(6'h06, 16'h0000, 16'hfffe);
		idle();
		rdc(6'h04, 16'h0000, 16'h0000);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rq[STAT_TOKEN], 1'b1);
		go(6'h06, 16'h0000, 16'h0001);
		idle();
		rdc(6'h04, 16'h0000, 16'hffff);
		far_flag(1'b0);
		go(6'h06, 16'h0000, 16'h0000);
		idle();
		rdc(6'h04, 16'h0000, 16'hffff);
		far_flag(1'b1);
		rdc(6'h04, 16'h0000, 16'h0000);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rq[STAT_TOKEN], 1'b1);
		go(6'h06, 16'h0000, 16'h0001);
		idle();
		go(6'h06, 16'h0000, 16'h0000);
		far_flag(1'b0);
		idle();
		rdc(6'h04, 16'h0000, 16'h0000);
		go(6'h06, 16'h0000, 16'h0001);
		idle();
		rdc(6'h04, 16'h0000, 16'hffff);
		far_flag(1'b1);
		$display("test flag done");
		far <= 1'b1;
		@(posedge clk);
		far <= 1'b0;
		repeat (4) @(posedge clk);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rq[STAT_MAILBOX], 1'b1);
		rdc(6'h18, MBOX_LEFT_WORD, 16'h0000);
		idle();
		chk(rq[STAT_MAILBOX], 1'b0);
		go(6'h1a, MBOX_RIGHT_WORD, 16'h0001);
		idle();
		chk(fmb, 1'b0);
		$display("test mailbox done");
		ebusy_n <= 1'b0;
		go(6'h1a, 16'h0005, 16'hbeef);
		wb(1'b1, REG_ADDR, 32'h9);
		repeat (10) @(posedge clk);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rq[4:0], 5'h15);
		ebusy_n <= 1'b1;
		idle();
		wb(1'b0, REG_ADDR, 32'h0);
		chk(rq, 32'h5);
		ebusy_n <= 1'b0;
		rdc(6'h38, 16'h0005, 16'hbeef);
		chk(role, 1'b1);
		far_hold <= 1'b1;
		go(6'h38, 16'h0005, 16'h0000);
		repeat (10) @(posedge clk);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rq[4:0], 5'h15);
		far_hold <= 1'b0;
		idle();
		wb(1'b0, REG_RDATA, 32'h0);
		chk(rq, 32'hbeef);
		$display("test busy done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
